// *** include/cbirq_pkg.sv ***
package cbirq_pkg;
   // processor clock divide from the main oscillator
   localparam int unsigned OSC_HZ = 125000000;
   localparam int unsigned CPU_HZ = 10000000;
   localparam logic [3:0] CPU_DIV = 4'(OSC_HZ / 40000000);
   // reset pulse length
   localparam int unsigned RESET_PULSE_MS = 200;
   localparam longint unsigned RESET_PULSE_CYC = longint'(RESET_PULSE_MS) * longint'(OSC_HZ) / 1000;
   localparam int unsigned POWER_SYNC_CYC = 2;
   localparam logic [2:0] LEVEL_NONE = 3'h0;
   localparam logic [2:0] LEVEL_DMA = 3'h6;
   localparam int unsigned NUM_CH = 4;
   typedef enum logic [2:0] {
      CBIRQ_IDLE = 3'h0,
      CBIRQ_REQ = 3'h1,
      CBIRQ_READ = 3'h2,
      CBIRQ_WRITE = 3'h3,
      CBIRQ_RELEASE = 3'h4
   } cbirq_state_t;
endpackage : cbirq_pkg

// *** src/cbirq_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbirq_encoder (
   input wire logic [7:1] req,
   output logic [2:0] level
);
   ////////////////////////////////////////////////////////////////////////
   // highest pending level wins, none gives zero
   always_comb begin
      level = cbirq_pkg::LEVEL_NONE;
      for (int i = 1; i <= 7; i++) begin
         if (req[i]) begin
            level = 3'(i);
         end
      end
   end
endmodule : cbirq_encoder
`default_nettype wire

// *** src/cbirq_reset_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbirq_reset_gen #(
   parameter longint unsigned PULSE_CYC = cbirq_pkg::RESET_PULSE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic power_good,
   output logic system_reset
);
   logic [1:0] sync;
   logic [31:0] count;
   ////////////////////////////////////////////////////////////////////////
   // two-stage sync of the supply monitor
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync <= 2'h0;
      end else begin
         sync <= {sync[0], power_good};
      end
   end
   // any supply dip restarts the full pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 32'h0;
         system_reset <= 1'b1;
      end else if (!sync[1]) begin
         count <= 32'h0;
         system_reset <= 1'b1;
      end else if (count < 32'(PULSE_CYC)) begin
         count <= count + 32'h1;
         system_reset <= 1'b1;
      end else begin
         system_reset <= 1'b0;
      end
   end
endmodule : cbirq_reset_gen
`default_nettype wire

// *** src/cbirq_top.sv ***
//
// Overview of operation
// - Seven request levels encoded to three bits
// - Fixed source ranking power-fail seven down
// - Autovector all acknowledges except the DMA
// - Power-on or dip gives long reset pulse
// - Processor clock is divided oscillator
// - Sampling logic uses a separate clock
// - DMA side runs synchronous with processor
// - Processor masters bus except DMA transfers
// - Four channels with fixed data roles
// - Channel three request selects disk or CRT
// - Active-low bus request, wait for grant
// - First read word into internal buffer
// - Then write buffered word to memory
// - Release bus after each single transfer
// - Split multiplexed address from data
// - Grant acknowledge shows bus busy
// - Completion pulse ends channel transfer
// - DMA service request feeds level six
// - Bus buffer off in DMA acknowledge
//
`timescale 1ns/1ps
`default_nettype none
module cbirq_top #(
   parameter longint unsigned RESET_PULSE_CYC = cbirq_pkg::RESET_PULSE_CYC
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic POWER_GOOD,
   input wire logic POWER_FAIL_WARNING,
   input wire logic DMA_SERVICE_REQUEST,
   input wire logic CRT_IRQ,
   input wire logic TIMER_IRQ,
   input wire logic KEY_IRQ,
   input wire logic GPIB_IRQ,
   input wire logic FLOPPY_CONTROLLER_IRQ,
   input wire logic INTERRUPT_ACKNOWLEDGE,
   input wire logic [2:0] ACK_LEVEL,
   input wire logic PRETRIGGER_XFER_REQUEST,
   input wire logic POSTTRIGGER_XFER_REQUEST,
   input wire logic GPIB_XFER_REQUEST,
   input wire logic FLOPPY_XFER_REQUEST,
   input wire logic CRT_XFER_REQUEST,
   input wire logic CH3_SELECT_CRT,
   input wire logic BUS_GRANT_N,
   input wire logic [23:0] MUX_AD,
   input wire logic ADDR_STROBE,
   input wire logic [15:0] SAMPLE_DATA,
   output logic [2:0] PROCESSOR_IPL,
   output logic AUTOVECTOR,
   output logic BUS_ENABLE,
   output logic SYSTEM_RESET,
   output logic PROCESSOR_CLOCK,
   output logic BUS_REQUEST_N,
   output logic BUS_GRANT_ACK,
   output logic DMA_OWNS_BUS,
   output logic [1:0] ACTIVE_CHANNEL,
   output logic XFER_READ,
   output logic XFER_WRITE,
   output logic [15:0] XFER_DATA,
   output logic [23:0] LATCHED_ADDRESS,
   output logic [3:0] DONE_PULSE
);
   logic [7:1] irq_sync1, irq_sync2;
   logic [2:0] irq_level;
   logic [4:0] dreq_sync1, dreq_sync2;
   logic [3:0] chan_req;
   logic ack_sync1, ack_sync2, grant_sync1, grant_sync2;
   logic [2:0] lvl_sync1, lvl_sync2;
   logic sel_sync1, sel_sync2;
   logic [3:0] div_count;
   logic cpu_tick;
   cbirq_pkg::cbirq_state_t state, next_state;
   logic [1:0] chan;

   function automatic logic [1:0] pick_channel(input logic [3:0] r);
      pick_channel = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (r[i]) begin
            pick_channel = 2'(i);
         end
      end
   endfunction : pick_channel

   ////////////////////////////////////////////////////////////////////////
   // interrupt inputs, external pins so synchronised
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_sync1 <= 7'h00;
         irq_sync2 <= 7'h00;
      end else begin
         irq_sync1 <= {POWER_FAIL_WARNING, DMA_SERVICE_REQUEST, CRT_IRQ, TIMER_IRQ, KEY_IRQ, GPIB_IRQ,
                       FLOPPY_CONTROLLER_IRQ};
         irq_sync2 <= irq_sync1;
      end
   end

   cbirq_encoder u_enc (
      .req(irq_sync2),
      .level(irq_level)
   );

   // encoded level registered so the processor sees no glitches
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PROCESSOR_IPL <= cbirq_pkg::LEVEL_NONE;
      end else begin
         PROCESSOR_IPL <= irq_level;
      end
   end

   // acknowledge decode
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ack_sync1 <= 1'b0;
         ack_sync2 <= 1'b0;
         lvl_sync1 <= 3'h0;
         lvl_sync2 <= 3'h0;
      end else begin
         ack_sync1 <= INTERRUPT_ACKNOWLEDGE;
         ack_sync2 <= ack_sync1;
         lvl_sync1 <= ACK_LEVEL;
         lvl_sync2 <= lvl_sync1;
      end
   end
   // level rides the same two stages as the strobe, so both land together
   always_comb begin
      AUTOVECTOR = ack_sync2 && (lvl_sync2 != cbirq_pkg::LEVEL_DMA);
      BUS_ENABLE = !(ack_sync2 && (lvl_sync2 == cbirq_pkg::LEVEL_DMA));
   end

   ////////////////////////////////////////////////////////////////////////
   // reset pulse
   cbirq_reset_gen #(
      .PULSE_CYC(RESET_PULSE_CYC)
   ) u_rst (
      .clk(CLK),
      .reset_n(RESET_N),
      .power_good(POWER_GOOD),
      .system_reset(SYSTEM_RESET)
   );

   ////////////////////////////////////////////////////////////////////////
   // processor clock divider; dma engine steps on its tick
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_count <= 4'h0;
         PROCESSOR_CLOCK <= 1'b0;
      end else if (div_count >= cbirq_pkg::CPU_DIV) begin
         div_count <= 4'h0;
         PROCESSOR_CLOCK <= !PROCESSOR_CLOCK;
      end else begin
         div_count <= div_count + 4'h1;
      end
   end
   // one enable per processor clock period keeps dma synchronous
   assign cpu_tick = (div_count >= cbirq_pkg::CPU_DIV) && PROCESSOR_CLOCK;

   ////////////////////////////////////////////////////////////////////////
   // dma requests; sample controller drives its own clock domain
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         dreq_sync1 <= 5'h00;
         dreq_sync2 <= 5'h00;
         grant_sync1 <= 1'b1;
         grant_sync2 <= 1'b1;
         sel_sync1 <= 1'b0;
         sel_sync2 <= 1'b0;
      end else begin
         dreq_sync1 <= {CRT_XFER_REQUEST, FLOPPY_XFER_REQUEST, GPIB_XFER_REQUEST, POSTTRIGGER_XFER_REQUEST,
                        PRETRIGGER_XFER_REQUEST};
         dreq_sync2 <= dreq_sync1;
         grant_sync1 <= BUS_GRANT_N;
         grant_sync2 <= grant_sync1;
         sel_sync1 <= CH3_SELECT_CRT;
         sel_sync2 <= sel_sync1;
      end
   end
   // only channel three is shared
   always_comb begin
      chan_req[2:0] = dreq_sync2[2:0];
      chan_req[3] = sel_sync2 ? dreq_sync2[4] : dreq_sync2[3];
   end

   ////////////////////////////////////////////////////////////////////////
   // cycle-steal sequencer, one word per bus tenure
   always_comb begin
      next_state = state;
      case (state)
         cbirq_pkg::CBIRQ_IDLE: begin
            if (chan_req != 4'h0) begin
               next_state = cbirq_pkg::CBIRQ_REQ;
            end
         end
         cbirq_pkg::CBIRQ_REQ: begin
            if (!grant_sync2) begin
               next_state = cbirq_pkg::CBIRQ_READ;
            end
         end
         cbirq_pkg::CBIRQ_READ: next_state = cbirq_pkg::CBIRQ_WRITE;
         cbirq_pkg::CBIRQ_WRITE: next_state = cbirq_pkg::CBIRQ_RELEASE;
         cbirq_pkg::CBIRQ_RELEASE: next_state = cbirq_pkg::CBIRQ_IDLE;
         default: next_state = cbirq_pkg::CBIRQ_IDLE;
      endcase
   end
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= cbirq_pkg::CBIRQ_IDLE;
      end else if (cpu_tick) begin
         state <= next_state;
      end
   end

   // channel captured at request so it cannot change mid transfer
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         chan <= 2'h0;
      end else if (cpu_tick && state == cbirq_pkg::CBIRQ_IDLE) begin
         chan <= pick_channel(chan_req);
      end
   end

   // bus ownership outputs, processor is master otherwise
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         BUS_REQUEST_N <= 1'b1;
         BUS_GRANT_ACK <= 1'b0;
         DMA_OWNS_BUS <= 1'b0;
         XFER_READ <= 1'b0;
         XFER_WRITE <= 1'b0;
      end else if (cpu_tick) begin
         BUS_REQUEST_N <= !(next_state == cbirq_pkg::CBIRQ_REQ);
         BUS_GRANT_ACK <= next_state == cbirq_pkg::CBIRQ_READ || next_state == cbirq_pkg::CBIRQ_WRITE;
         DMA_OWNS_BUS <= next_state == cbirq_pkg::CBIRQ_READ || next_state == cbirq_pkg::CBIRQ_WRITE;
         XFER_READ <= next_state == cbirq_pkg::CBIRQ_READ;
         XFER_WRITE <= next_state == cbirq_pkg::CBIRQ_WRITE;
      end
   end

   // internal word buffer, filled in read, driven in write
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         XFER_DATA <= 16'h0000;
      end else if (cpu_tick && state == cbirq_pkg::CBIRQ_READ) begin
         XFER_DATA <= SAMPLE_DATA;
      end
   end

   // address latch splits the multiplexed bus
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         LATCHED_ADDRESS <= 24'h000000;
      end else if (ADDR_STROBE) begin
         LATCHED_ADDRESS <= MUX_AD;
      end
   end

   // completion pulse per channel after the write
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DONE_PULSE <= 4'h0;
         ACTIVE_CHANNEL <= 2'h0;
      end else begin
         DONE_PULSE <= 4'h0;
         ACTIVE_CHANNEL <= chan;
         if (cpu_tick && state == cbirq_pkg::CBIRQ_WRITE) begin
            DONE_PULSE <= 4'h1 << chan;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_bus_exclusive: assert property (@(posedge CLK) disable iff (!RESET_N)
      BUS_GRANT_ACK |-> BUS_REQUEST_N) else $error("request and ownership overlap");
   a_read_then_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(XFER_READ) |-> XFER_WRITE) else $error("write did not follow read");
   a_level_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      (irq_sync2 == 7'h00) |=> PROCESSOR_IPL == 3'h0) else $error("level not zero when idle");
   a_power_fail_warning_top: assert property (@(posedge CLK) disable iff (!RESET_N)
      irq_sync2[7] |=> PROCESSOR_IPL == 3'h7) else $error("power fail not top level");
   a_dma_vector: assert property (@(posedge CLK) disable iff (!RESET_N)
      (ack_sync2 && lvl_sync2 == 3'h6) |-> !AUTOVECTOR && !BUS_ENABLE) else $error("dma ack autovectored");
   a_done_after_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      (DONE_PULSE != 4'h0) |-> $past(state) == cbirq_pkg::CBIRQ_WRITE) else $error("done out of place");
   a_release_bus: assert property (@(posedge CLK) disable iff (!RESET_N)
      $fell(XFER_WRITE) |-> !BUS_GRANT_ACK) else $error("bus kept after transfer");
   a_owns_ack: assert property (@(posedge CLK) disable iff (!RESET_N)
      DMA_OWNS_BUS == BUS_GRANT_ACK) else $error("busy status mismatch");
   a_dma_level: assert property (@(posedge CLK) disable iff (!RESET_N)
      (irq_sync2[6] && !irq_sync2[7]) |=> PROCESSOR_IPL == 3'h6) else $error("dma service not level six");
   a_one_phase: assert property (@(posedge CLK) disable iff (!RESET_N)
      XFER_READ |-> !XFER_WRITE) else $error("read and write overlap");
   a_grant_first: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(BUS_GRANT_ACK) |-> !$past(grant_sync2)) else $error("bus taken before grant");
   c_transfer: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(XFER_WRITE));
   c_dma_ack: cover property (@(posedge CLK) disable iff (!RESET_N) ack_sync2 && !BUS_ENABLE);
   c_ch3: cover property (@(posedge CLK) disable iff (!RESET_N) DONE_PULSE[3]);
   c_autovector: cover property (@(posedge CLK) disable iff (!RESET_N) AUTOVECTOR);
   c_channel_one: cover property (@(posedge CLK) disable iff (!RESET_N) DONE_PULSE[1]);
endmodule : cbirq_top
`default_nettype wire

// *** testbench/cbirq_bus_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module cbirq_bus_partner (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic bus_request_n,
   input wire logic xfer_read,
   input wire logic slow,
   input wire logic [15:0] word,
   output logic bus_grant_n,
   output logic [15:0] sample_data
);
   logic [3:0] wait_cnt;
   logic [15:0] noise;
   ////////////////////////////////////////////////////////////////////////////
   // processor side: grants only after the request has stood a while
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_grant_n <= 1'h1;
         wait_cnt <= 4'h0;
      end else if (bus_request_n) begin
         bus_grant_n <= 1'h1;
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= (slow ? 4'hC : 4'h1)) begin
         bus_grant_n <= 1'h0;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // data lines wander outside the read phase so a stale capture shows up
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) noise <= 16'h0F0F;
      else noise <= noise + 16'h1357;
   end
   assign sample_data = xfer_read ? word : noise;
endmodule : cbirq_bus_partner
`default_nettype wire

// *** testbench/tb_cbirq_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cbirq_top;
   localparam longint unsigned PULSE = 20;
   // irq, ack, ack level, expected level, autovector, bus enable
   localparam logic [15:0] ROWS [14] = '{
      {7'h00, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1}, {7'h01, 1'h0, 3'h0, 3'h1, 1'h0, 1'h1},
      {7'h03, 1'h0, 3'h0, 3'h2, 1'h0, 1'h1}, {7'h06, 1'h0, 3'h0, 3'h3, 1'h0, 1'h1},
      {7'h0C, 1'h0, 3'h0, 3'h4, 1'h0, 1'h1}, {7'h18, 1'h0, 3'h0, 3'h5, 1'h0, 1'h1},
      {7'h30, 1'h0, 3'h0, 3'h6, 1'h0, 1'h1}, {7'h7F, 1'h0, 3'h0, 3'h7, 1'h0, 1'h1},
      {7'h14, 1'h0, 3'h0, 3'h5, 1'h0, 1'h1}, {7'h20, 1'h1, 3'h6, 3'h6, 1'h0, 1'h0},
      {7'h04, 1'h1, 3'h3, 3'h3, 1'h1, 1'h1}, {7'h40, 1'h1, 3'h7, 3'h7, 1'h1, 1'h1},
      {7'h01, 1'h1, 3'h1, 3'h1, 1'h1, 1'h1}, {7'h00, 1'h0, 3'h0, 3'h0, 1'h0, 1'h1}};
   logic clk = 1'h0, reset_n = 1'h0, power_good = 1'h1, ack = 1'h0, sel = 1'h0, strobe = 1'h0, slow = 1'h0;
   logic [7:1] irq = 7'h00;
   logic [2:0] ack_lvl = 3'h0;
   logic [4:0] xreq = 5'h00;
   logic [23:0] mux_ad = 24'h000000;
   logic [15:0] word = 16'h0000;
   logic [2:0] ipl;
   logic av, be, sys_rst, pclk, br_n, bg_n, bga, own, rd, wr, prev;
   logic [1:0] ch;
   logic [15:0] xdata, sdata;
   logic [23:0] laddr;
   logic [3:0] done;
   int err_count = 0, tests_run = 0, i, n, tog;
   ////////////////////////////////////////////////////////////////////////////
   // half period of 4 ns gives the 125 MHz clock
   always #4 clk = ~clk;
   cbirq_top #(.RESET_PULSE_CYC(PULSE)) dut (.CLK(clk), .RESET_N(reset_n), .POWER_GOOD(power_good),
      .POWER_FAIL_WARNING(irq[7]), .DMA_SERVICE_REQUEST(irq[6]), .CRT_IRQ(irq[5]), .TIMER_IRQ(irq[4]),
      .KEY_IRQ(irq[3]), .GPIB_IRQ(irq[2]), .FLOPPY_CONTROLLER_IRQ(irq[1]), .INTERRUPT_ACKNOWLEDGE(ack),
      .ACK_LEVEL(ack_lvl), .PRETRIGGER_XFER_REQUEST(xreq[0]), .POSTTRIGGER_XFER_REQUEST(xreq[1]),
      .GPIB_XFER_REQUEST(xreq[2]), .FLOPPY_XFER_REQUEST(xreq[3]), .CRT_XFER_REQUEST(xreq[4]),
      .CH3_SELECT_CRT(sel), .BUS_GRANT_N(bg_n), .MUX_AD(mux_ad), .ADDR_STROBE(strobe), .SAMPLE_DATA(sdata),
      .PROCESSOR_IPL(ipl), .AUTOVECTOR(av), .BUS_ENABLE(be), .SYSTEM_RESET(sys_rst), .PROCESSOR_CLOCK(pclk),
      .BUS_REQUEST_N(br_n), .BUS_GRANT_ACK(bga), .DMA_OWNS_BUS(own), .ACTIVE_CHANNEL(ch), .XFER_READ(rd),
      .XFER_WRITE(wr), .XFER_DATA(xdata), .LATCHED_ADDRESS(laddr), .DONE_PULSE(done));
   cbirq_bus_partner partner (.clk(clk), .reset_n(reset_n), .bus_request_n(br_n), .xfer_read(rd),
      .slow(slow), .word(word), .bus_grant_n(bg_n), .sample_data(sdata));
   ////////////////////////////////////////////////////////////////////////////
   // one counted comparison, reported at once on a miss
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'h1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask : check
   task automatic test_done;
      if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   // counts cycles until the reset pulse ends, bounded
   task automatic pulse_len;
      for (n = 0; n < 200 && sys_rst !== 1'h0; n++) @(negedge clk);
   endtask : pulse_len
   // one whole stolen-cycle transfer; requests drop once the read shows
   task automatic dma(input logic [4:0] rq, input logic s, input logic [1:0] c, input logic [15:0] w);
      sel = s;
      word = w;
      xreq = rq;
      for (n = 0; n < 100 && br_n !== 1'h0; n++) @(negedge clk);
      check(n < 100 && bga === 1'h0, "bus request");
      for (n = 0; n < 100 && rd !== 1'h1; n++) @(negedge clk);
      check(n < 100 && bg_n === 1'h0 && bga === 1'h1 && own === 1'h1, "bus tenure");
      check(ch === c, "channel");
      xreq = 5'h00;
      for (n = 0; n < 20 && wr !== 1'h1; n++) @(negedge clk);
      check(n < 20 && rd === 1'h0 && xdata === w, "buffered word");
      for (n = 0; n < 20 && done === 4'h0; n++) @(negedge clk);
      check(done === (4'h1 << c), "done pulse");
      @(negedge clk);
      check(done === 4'h0, "done width");
      for (n = 0; n < 20 && bga !== 1'h0; n++) @(negedge clk);
      check(n < 20 && own === 1'h0, "bus release");
      repeat (20) @(negedge clk);
      check(br_n === 1'h1, "single transfer");
   endtask : dma
   ////////////////////////////////////////////////////////////////////////////
   // hang guard, far beyond the several hundred cycles the run needs
   initial begin
      #200000;
      err_count++;
      test_done();
   end
   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      check(sys_rst === 1'h1 && br_n === 1'h1 && ipl === 3'h0, "reset state");
      repeat (3) @(negedge clk);
      reset_n = 1'h1;
      pulse_len();
      check(n >= PULSE && n <= PULSE + 10, "power-on pulse");
      for (i = 0; i < 14; i++) begin
         {irq, ack, ack_lvl} = ROWS[i][15:5];
         repeat (5) @(negedge clk);
         check(ipl === ROWS[i][4:2], "priority level");
         check(av === ROWS[i][1], "autovector");
         check(be === ROWS[i][0], "bus enable");
      end
      // divided clock: toggles once every CPU_DIV+1 cycles
      prev = pclk;
      tog = 0;
      repeat (64) begin
         @(negedge clk);
         if (pclk !== prev) tog++;
         prev = pclk;
      end
      check(tog == 64 / (int'(cbirq_pkg::CPU_DIV) + 1), "processor clock");
      mux_ad = 24'h5A3C96;
      strobe = 1'h1;
      @(negedge clk);
      strobe = 1'h0;
      mux_ad = 24'hA5C369;
      repeat (2) @(negedge clk);
      check(laddr === 24'h5A3C96, "address latch");
      dma(5'h05, 1'h0, 2'h0, 16'hA5C3);
      dma(5'h02, 1'h0, 2'h1, 16'h3C5A);
      slow = 1'h1;
      dma(5'h04, 1'h0, 2'h2, 16'hFFFF);
      dma(5'h10, 1'h1, 2'h3, 16'h0001);
      dma(5'h08, 1'h0, 2'h3, 16'h8000);
      // floppy request while the selector routes the display controller
      sel = 1'h1;
      xreq = 5'h08;
      repeat (40) @(negedge clk);
      check(br_n === 1'h1, "unselected request");
      xreq = 5'h00;
      power_good = 1'h0;
      repeat (4) @(negedge clk);
      check(sys_rst === 1'h1, "supply dip");
      power_good = 1'h1;
      pulse_len();
      check(n >= PULSE && n < 200, "dip pulse");
      test_done();
   end
endmodule : tb_cbirq_top
`default_nettype wire
